// ---- queued_write_taskfile_outputs.v ----
// Register access over Avalon-MM and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "qwrite_consts.vh"

module queued_write_taskfile_outputs #(
	parameter QUEUE_DEPTH = 32,              // Supported tags are below this value
	parameter [31:0] DEVICE_ID = 32'h0000_1234 // Arbitrary identity value
) (
	input  wire        ref_clk,           // 100 MHz clock
	input  wire        rst_n,             // Synchronous reset, active low
	input  wire        clk_en,            // Freezes all state while low
	input  wire [5:0]  avs_address,       // Word index
	input  wire        avs_read,          // Read strobe
	input  wire        avs_write,         // Write strobe
	input  wire [31:0] avs_writedata,     // Write data
	input  wire [3:0]  avs_byteenable,    // Byte enables
	output reg  [31:0] avs_readdata,      // Read data
	output wire        avs_waitrequest,   // Stall
	output wire        bus_released,      // Command released the bus
	output wire        dma_write_active,  // Queued write in progress, bus not released
	output wire        pio_write_active   // Multiple write accepted
);

	localparam ST_IDLE = 2'd0;
	localparam ST_REL  = 2'd1;
	localparam ST_XFER = 2'd2;
	localparam ST_PIO  = 2'd3;

	reg  [1:0]  state_q;
	reg  [7:0]  fault_flags_q;
	reg  [7:0]  count_tag_q;
	reg  [7:0]  addr_low_q;
	reg  [7:0]  addr_mid_q;
	reg  [7:0]  addr_high_q;
	reg  [7:0]  drive_head_q;
	reg  [7:0]  device_state_q;
	reg  [7:0]  feature_q;
	reg  [8:0]  env_q;
	reg  [4:0]  cur_tag_q;
	reg         media_chg_det_q;
	reg         chg_req_q;
	reg         queue_valid_q;
	reg  [8:0]  sect_total_q;
	reg         ack_q;

	wire        req      = (avs_read | avs_write) & ~ack_q;
	// Writes land on the answer edge, where waitrequest is low
	wire        wr_go    = avs_write & ack_q & clk_en;
	wire [3:0]  idx      = avs_address[3:0];
	wire        hi_zero  = (avs_address[5:4] == 2'b00);

	// One wait cycle on every access while clk_en is high
	assign avs_waitrequest  = (avs_read | avs_write) & ~ack_q;
	assign bus_released     = (state_q == ST_REL);
	assign dma_write_active = (state_q == ST_XFER);
	assign pio_write_active = (state_q == ST_PIO);

	// Write strobe for one register index
	function hit;
		input [3:0] i;
		input [3:0] want;
		input       en;
		begin
			hit = en & (i == want);
		end
	endfunction

	wire        env_wr  = hit(idx, `IDX_ENV_CTRL, wr_go & hi_zero & avs_byteenable[0]);
	wire        ev_wr   = hit(idx, `IDX_EVENT_CTRL, wr_go & hi_zero);
	wire        op_wr   = hit(idx, `IDX_OPCODE, wr_go & hi_zero & avs_byteenable[0]);
	wire [7:0]  opcode  = avs_writedata[7:0];
	wire [10:0] ev      = ev_wr ? avs_writedata[10:0] : 11'h000;
	wire        queue_sup = env_q[`EC_QUEUE_SUP];
	wire [4:0]  in_tag  = count_tag_q[`CT_TAG_HI:`CT_TAG_LO];
	wire        tag_bad = queue_sup & ({27'd0, in_tag} >= QUEUE_DEPTH);
	wire [7:0]  tag_out = queue_sup ? {cur_tag_q, 3'b000} : `ZERO_BYTE;
	wire        dev_bit = drive_head_q[`DH_DEV];
	wire        sel_lba = drive_head_q[`DH_LBA];
	wire [27:0] start_addr = {drive_head_q[`DH_HEAD_HI:`DH_HEAD_LO], addr_high_q,
	                          addr_mid_q, addr_low_q};

	// Status pattern for completions and errors
	function [7:0] done_status;
		input fault;
		input service_pending;
		input err;
		begin
			done_status = `ZERO_BYTE;
			done_status[`ST_READY] = 1'b1;
			done_status[`ST_FAULT] = fault;
			done_status[`ST_SERVICE_PENDING]  = service_pending;
			done_status[`ST_ERR]   = err;
		end
	endfunction

	// Error flag set for a terminated command
	reg [7:0] err_flags;
	always @* begin
		err_flags = `ZERO_BYTE;
		err_flags[`FF_INTERFACE_CRC_FLAG]  = ev[`EV_CRC_ERR] & env_q[`EC_UDMA];
		err_flags[`FF_WP]    = env_q[`EC_REMOVABLE] & env_q[`EC_WR_PROT];
		err_flags[`FF_NM]    = env_q[`EC_REMOVABLE] & env_q[`EC_NO_MEDIUM];
		err_flags[`FF_MC]    = env_q[`EC_REMOVABLE] & media_chg_det_q;
		err_flags[`FF_MCR]   = chg_req_q;
		err_flags[`FF_ADDRESS_NOT_FOUND]  = ev[`EV_ADDR_NF] | env_q[`EC_GEOM_BAD];
		err_flags[`FF_ABORT_FLAG]  = (ev[`EV_CRC_ERR] & env_q[`EC_UDMA]) |
		                       (ev[`EV_RANGE_ERR] & ~err_flags[`FF_ADDRESS_NOT_FOUND]);
	end

	wire term_err = ev[`EV_CRC_ERR] | ev[`EV_MEDIA_ERR] | ev[`EV_RANGE_ERR] | ev[`EV_ADDR_NF];

	// Register file, command decode and transfer sequencing
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			state_q         <= ST_IDLE;
			fault_flags_q   <= `ZERO_BYTE;
			count_tag_q     <= `ZERO_BYTE;
			addr_low_q      <= `ZERO_BYTE;
			addr_mid_q      <= `ZERO_BYTE;
			addr_high_q     <= `ZERO_BYTE;
			drive_head_q    <= `ZERO_BYTE;
			device_state_q  <= `STATE_RESET;
			feature_q       <= `ZERO_BYTE;
			env_q           <= 9'h000;
			cur_tag_q       <= 5'd0;
			media_chg_det_q <= 1'b0;
			chg_req_q       <= 1'b0;
			queue_valid_q   <= 1'b0;
			sect_total_q    <= 9'h000;
			ack_q           <= 1'b0;
		end else if (clk_en) begin
			ack_q <= req;
			if (wr_go & hi_zero & avs_byteenable[0]) begin
				case (idx)
				`IDX_COUNT_TAG:  count_tag_q  <= avs_writedata[7:0];
				`IDX_ADDR_LOW:   addr_low_q   <= avs_writedata[7:0];
				`IDX_ADDR_MID:   addr_mid_q   <= avs_writedata[7:0];
				`IDX_ADDR_HIGH:  addr_high_q  <= avs_writedata[7:0];
				`IDX_DRIVE_HEAD: drive_head_q <= avs_writedata[7:0];
				`IDX_FEATURE:    feature_q    <= avs_writedata[7:0];
				default: ;
				endcase
			end
			if (env_wr)
				env_q <= {avs_writedata[8] & avs_byteenable[1], avs_writedata[7:0]};
			// Detection sets win over clears in the same cycle
			if (ev[`EV_MEDIA_CHG])
				media_chg_det_q <= 1'b1;
			if (ev[`EV_CHG_REQ])
				chg_req_q <= 1'b1;
			else if (ev[`EV_MEDIA_CMD])
				chg_req_q <= 1'b0;
			if (op_wr) begin
				if (opcode == `OP_WRITE_DMA_Q) begin
					if (!env_q[`EC_OVL_INT_EN] | tag_bad) begin
						fault_flags_q  <= 8'h01 << `FF_ABORT_FLAG;
						device_state_q <= done_status(env_q[`EC_DEV_FAULT], 1'b0, 1'b1);
						state_q        <= ST_IDLE;
					end else begin
						cur_tag_q      <= in_tag;
						queue_valid_q  <= 1'b1;
						state_q        <= ST_XFER;
						device_state_q <= 8'h01 << `ST_BUSY;
					end
				end else if (opcode == `OP_WRITE_MULTI) begin
					sect_total_q   <= (count_tag_q == `ZERO_BYTE) ? `SECT_256 : {1'b0, count_tag_q};
					state_q        <= ST_PIO;
					device_state_q <= done_status(1'b0, 1'b0, 1'b0) | (8'h01 << `ST_DRQ);
				end else if (opcode == `OP_SERVICE && state_q == ST_REL) begin
					count_tag_q    <= tag_out | (8'h01 << `CT_REL);
					state_q        <= ST_XFER;
					device_state_q <= done_status(1'b0, env_q[`EC_OTHER_READY], 1'b0) | (8'h01 << `ST_DRQ);
				end else begin
					fault_flags_q  <= 8'h01 << `FF_ABORT_FLAG;
					device_state_q <= done_status(env_q[`EC_DEV_FAULT], 1'b0, 1'b1);
				end
			end else begin
				case (state_q)
				ST_XFER: begin
					// Release only allowed before data starts
					if (ev[`EV_RELEASE] && device_state_q[`ST_DRQ] == 1'b0) begin
						count_tag_q    <= tag_out | (8'h01 << `CT_REL);
						device_state_q <= done_status(1'b0, env_q[`EC_OTHER_READY], 1'b0);
						state_q        <= ST_REL;
					end else if (ev[`EV_DATA_START]) begin
						device_state_q <= done_status(1'b0, env_q[`EC_OTHER_READY], 1'b0) | (8'h01 << `ST_DRQ);
						count_tag_q    <= tag_out;
					end else if (term_err) begin
						fault_flags_q  <= err_flags;
						count_tag_q    <= tag_out | (8'h01 << `CT_IO) | (8'h01 << `CT_CD);
						device_state_q <= done_status(env_q[`EC_DEV_FAULT], env_q[`EC_OTHER_READY],
						                              |err_flags);
						addr_low_q     <= avs_writedata[23:16];
						addr_mid_q     <= avs_writedata[31:24];
						media_chg_det_q <= ev[`EV_MEDIA_CHG];                            // New change wins
						queue_valid_q  <= 1'b0;
						state_q        <= ST_IDLE;
					end else if (ev[`EV_DATA_DONE]) begin
						fault_flags_q  <= `ZERO_BYTE;
						count_tag_q    <= tag_out | (8'h01 << `CT_IO) | (8'h01 << `CT_CD);
						device_state_q <= done_status(1'b0, env_q[`EC_OTHER_READY], 1'b0);
						queue_valid_q  <= 1'b0;
						state_q        <= ST_IDLE;
					end
				end
				ST_REL: begin
					if (ev[`EV_READY_SVC])
						device_state_q[`ST_SERVICE_PENDING] <= 1'b1;
				end
				ST_PIO: begin
					if (ev[`EV_DATA_DONE]) begin
						device_state_q <= done_status(1'b0, 1'b0, 1'b0);
						state_q        <= ST_IDLE;
					end
				end
				default: ;
				endcase
			end
		end
	end

	// Device state value passed unchanged; the live drive bit is read beside it at bit 8
	wire [7:0] state_view = {device_state_q[7:5], device_state_q[4], device_state_q[3:0]};

	// Read data mux, registered in the wait cycle and valid in the answer cycle
	always @(posedge ref_clk) begin
		if (!rst_n)
			avs_readdata <= 32'h0000_0000;
		else if (clk_en && avs_read && !ack_q) begin
			if (!hi_zero)
				avs_readdata <= `SLV_DEAD;
			else
				case (idx)
				4'h0:              avs_readdata <= DEVICE_ID;
				`IDX_FAULT_FLAGS:  avs_readdata <= {24'd0, fault_flags_q};
				`IDX_COUNT_TAG:    avs_readdata <= {24'd0, count_tag_q};
				`IDX_ADDR_LOW:     avs_readdata <= {24'd0, addr_low_q};
				`IDX_ADDR_MID:     avs_readdata <= {24'd0, addr_mid_q};
				`IDX_ADDR_HIGH:    avs_readdata <= {24'd0, addr_high_q};
				`IDX_DRIVE_HEAD:   avs_readdata <= {24'd0, drive_head_q};
				`IDX_DEVICE_STATE: avs_readdata <= {23'd0, dev_bit, state_view};
				`IDX_ENV_CTRL:     avs_readdata <= {23'd0, env_q};
				`IDX_START_ADDR:   avs_readdata <= {3'd0, sel_lba, start_addr};
				`IDX_CMD_INFO:     avs_readdata <= {13'd0, queue_valid_q, chg_req_q, media_chg_det_q,
				                                    sect_total_q, cur_tag_q, state_q};
				default:           avs_readdata <= 32'h0000_0000;
				endcase
		end
	end

endmodule

// ---- qwrite_consts.vh ----
`ifndef QWRITE_CONSTS_VH
`define QWRITE_CONSTS_VH
// Register indices; byte address is index times four
`define IDX_FAULT_FLAGS   4'h1
`define IDX_COUNT_TAG     4'h2
`define IDX_ADDR_LOW      4'h3
`define IDX_ADDR_MID      4'h4
`define IDX_ADDR_HIGH     4'h5
`define IDX_DRIVE_HEAD    4'h6
`define IDX_DEVICE_STATE  4'h7
`define IDX_FEATURE       4'h8
`define IDX_OPCODE        4'h9
`define IDX_ENV_CTRL      4'ha
`define IDX_EVENT_CTRL    4'hb
`define IDX_START_ADDR    4'hc
`define IDX_CMD_INFO      4'hd
// Opcodes
`define OP_WRITE_DMA_Q    8'hcc
`define OP_WRITE_MULTI    8'hc5
`define OP_SERVICE        8'ha2
// Fault flag bit positions
`define FF_INTERFACE_CRC_FLAG           7
`define FF_WP             6
`define FF_MC             5
`define FF_ADDRESS_NOT_FOUND           4
`define FF_MCR            3
`define FF_ABORT_FLAG           2
`define FF_NM             1
// Status bit positions
`define ST_BUSY           7
`define ST_READY          6
`define ST_FAULT          5
`define ST_SERVICE_PENDING           4
`define ST_DRQ            3
`define ST_ERR            0
// Count register fields
`define CT_TAG_HI         7
`define CT_TAG_LO         3
`define CT_REL            2
`define CT_IO             1
`define CT_CD             0
// Drive/head fields
`define DH_LBA            6
`define DH_DEV            4
`define DH_HEAD_HI        3
`define DH_HEAD_LO        0
// Environment control bits
`define EC_QUEUE_SUP      0
`define EC_OVL_INT_EN     1
`define EC_REMOVABLE      2
`define EC_WR_PROT        3
`define EC_NO_MEDIUM      4
`define EC_GEOM_BAD       5
`define EC_OTHER_READY    6
`define EC_DEV_FAULT      7
`define EC_UDMA           8
// Event control bits (write one to signal)
`define EV_DATA_START     0
`define EV_DATA_DONE      1
`define EV_CRC_ERR        2
`define EV_MEDIA_ERR      3
`define EV_RANGE_ERR      4
`define EV_ADDR_NF        5
`define EV_MEDIA_CHG      6
`define EV_CHG_REQ        7
`define EV_RELEASE        8
`define EV_READY_SVC      9
`define EV_MEDIA_CMD      10
// Misc
`define ZERO_BYTE         8'h00
`define SECT_256          9'h100
`define STATE_RESET       8'h40
`define SLV_DEAD          32'hdeadbeef
`endif

// ---- host_adapter.sv ----
`timescale 1ns/100ps
`include "qwrite_consts.vh"
// Host adapter model: Avalon master for the task-file registers
module host_adapter (
	input  wire        ref_clk,         // Clock
	input  wire [31:0] avs_readdata,    // Read data
	input  wire        avs_waitrequest, // Stall
	output reg  [5:0]  avs_address,     // Word index
	output reg         avs_read,        // Read strobe
	output reg         avs_write,       // Write strobe
	output reg  [31:0] avs_writedata,   // Write data
	output reg  [3:0]  avs_byteenable   // Byte enables
);
	// Idle bus from time zero
	initial begin
		avs_address = 6'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hf;
	end
	// One access, held until waitrequest is sampled low
	task automatic xfer(input rd, input [5:0] a, input [31:0] d, output [31:0] q);
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= rd;
		avs_write <= !rd;
		@(posedge ref_clk);
		while (avs_waitrequest)
			@(posedge ref_clk);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		avs_address <= ~a;   // Idle lines keep no stale value
		avs_writedata <= ~d;
	endtask
	// Issue a command only once the device reports ready
	task automatic issue(input [7:0] op);
		reg [31:0] s;
		s = 32'h0;
		while (!s[`ST_READY])
			xfer(1'b1, {2'b00, `IDX_DEVICE_STATE}, 32'h0, s);
		xfer(1'b0, {2'b00, `IDX_OPCODE}, {24'h0, op}, s);
	endtask
	// Reselect the device after a bus release
	task automatic service;
		reg [31:0] s;
		xfer(1'b0, {2'b00, `IDX_OPCODE}, {24'h0, `OP_SERVICE}, s);
	endtask
endmodule

// ---- qwrite_chk_sva.sv ----
`timescale 1ns/100ps
`include "qwrite_consts.vh"
// Port-level checks of the task-file block
module qwrite_chk (
	input wire        ref_clk,          // Clock
	input wire        rst_n,            // Reset, active low
	input wire        clk_en,           // Clock enable
	input wire [5:0]  avs_address,      // Word index
	input wire        avs_read,         // Read strobe
	input wire        avs_write,        // Write strobe
	input wire [31:0] avs_writedata,    // Write data
	input wire [31:0] avs_readdata,     // Read data
	input wire        avs_waitrequest,  // Stall
	input wire        bus_released,     // Bus released
	input wire        dma_write_active, // Queued write active
	input wire        pio_write_active  // Multiple write active
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	// Request decode
	wire req = avs_read | avs_write;
	wire rd_ok = avs_read & ~avs_waitrequest;
	wire rd_st = rd_ok & (avs_address == {2'b00, `IDX_DEVICE_STATE});
	wire wr_first = avs_write & avs_waitrequest;
	reg  started_q;
	// Remembers that the data phase began
	always @(posedge ref_clk) begin
		if (!rst_n || (started_q && !dma_write_active))
			started_q <= 1'b0;
		else if (wr_first && avs_address == {2'b00, `IDX_EVENT_CTRL} && avs_writedata[`EV_DATA_START])
			started_q <= 1'b1;
	end
	a_ack_next: assert property (req && avs_waitrequest && clk_en |=> !avs_waitrequest)
		else $error("no answer one cycle after request");
	a_ack_once: assert property (req && !avs_waitrequest |=> !req || avs_waitrequest)
		else $error("request answered twice");
	a_unmapped_rd: assert property (rd_ok && avs_address[5:4] != 2'b00 |-> avs_readdata == `SLV_DEAD)
		else $error("unmapped read value wrong");
	a_reset_idle: assert property ($rose(rst_n) |-> !bus_released && !dma_write_active && !pio_write_active)
		else $error("outputs busy after reset");
	a_no_release: assert property (started_q && dma_write_active |-> !bus_released)
		else $error("bus released during data phase");
	a_multi_start: assert property (wr_first && avs_address == {2'b00, `IDX_OPCODE} &&
		avs_writedata[7:0] == `OP_WRITE_MULTI && !dma_write_active && !bus_released |=> ##[0:2] pio_write_active)
		else $error("multiple write not started");
	a_status_idle: assert property (rd_st && !dma_write_active && !pio_write_active |-> !avs_readdata[`ST_DRQ])
		else $error("data request set while idle");
	a_release_st: assert property (rd_st && bus_released |-> !avs_readdata[`ST_BUSY] && avs_readdata[`ST_READY])
		else $error("status wrong after release");
	a_release_rel: assert property (rd_ok && avs_address == {2'b00, `IDX_COUNT_TAG} && bus_released |-> avs_readdata[`CT_REL])
		else $error("released flag clear after release");
endmodule
bind queued_write_taskfile_outputs qwrite_chk u_chk (.ref_clk, .rst_n, .clk_en, .avs_address, .avs_read, .avs_write,
	.avs_writedata, .avs_readdata, .avs_waitrequest, .bus_released, .dma_write_active, .pio_write_active);

// ---- tb.sv ----
`timescale 1ns/100ps
`include "qwrite_consts.vh"
// Self-checking bench for the queued write task-file block
module tb;
	reg         ref_clk;          // Clock
	reg         rst_n;            // Reset, active low
	reg         clk_en;           // Clock enable
	wire [5:0]  avs_address;      // Word index
	wire        avs_read;         // Read strobe
	wire        avs_write;        // Write strobe
	wire [31:0] avs_writedata;    // Write data
	wire [3:0]  avs_byteenable;   // Byte enables
	wire [31:0] avs_readdata;     // Read data
	wire        avs_waitrequest;  // Stall
	wire        bus_released;     // Bus released
	wire        dma_write_active; // Queued write active
	wire        pio_write_active; // Multiple write active
	integer     n_errors, checks, i;
	integer     cyc = 0;
	reg  [31:0] q;
	reg  [7:0]  lo, mid, hi, dh;
	reg  [4:0]  tag;
	host_adapter host (.ref_clk, .avs_readdata, .avs_waitrequest, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable);
	queued_write_taskfile_outputs DUT (.ref_clk, .rst_n, .clk_en, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .bus_released, .dma_write_active,
		.pio_write_active);
	// 100 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// Hang limit
	always @(posedge ref_clk) begin
		cyc = cyc + 1;
		if (cyc == 30000) begin
			n_errors = n_errors + 1;
			wrap_up;
		end
	end
	// Expected values
	function [31:0] f_start(input [7:0] l, input [7:0] m, input [7:0] h, input [7:0] d);
		f_start = {3'b000, d[`DH_LBA], d[3:0], h, m, l};
	endfunction
	function [31:0] f_count(input [4:0] t, input qs, input released_flag);
		f_count = {24'h0, qs ? t : 5'h00, released_flag, !released_flag, !released_flag};
	endfunction
	function [31:0] f_flags(input wp, input mc, input address_not_found, input media_change_request, input ab, input nm);
		f_flags = {24'h0, 1'b0, wp, mc, address_not_found, media_change_request, ab, nm, 1'b0};
	endfunction
	function [31:0] f_stat(input dv, input sv, input er, input df);
		f_stat = {23'h0, dv, 2'b01, df, sv, 3'b000, er};
	endfunction
	// Compare and report
	task chk(input [95:0] nm, input [31:0] e, input [31:0] g);
		checks = checks + 1;
		if (g !== e) begin
			n_errors = n_errors + 1;
			$display("MISMATCH %0s exp %h got %h", nm, e, g);
		end
	endtask
	// Register access helpers; status ignores its unused bits
	task w(input [3:0] a, input [31:0] d);
		host.xfer(1'b0, {2'b00, a}, d, q);
	endtask
	task rc(input [3:0] a, input [31:0] e, input [95:0] nm);
		host.xfer(1'b1, {2'b00, a}, 32'h0, q);
		chk(nm, e, (a == `IDX_DEVICE_STATE) ? (q & 32'h1f9) : q);
	endtask
	task ev(input integer b);
		w(`IDX_EVENT_CTRL, 32'h1 << b);
	endtask
	task rst_dut;
		rst_n <= 1'b0;
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
	endtask
	// Queued write with a random tag and drive bit
	task qcmd(input [31:0] env);
		tag = $urandom % 32;
		dh = $urandom;
		w(`IDX_ENV_CTRL, env);
		w(`IDX_COUNT_TAG, {24'h0, tag, 3'b000});
		w(`IDX_DRIVE_HEAD, {24'h0, dh});
		host.issue(`OP_WRITE_DMA_Q);
	endtask
	task wrap_up;
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Main sequence
	initial begin
		n_errors = 0;
		checks = 0;
		rst_n = 1'b0;
		clk_en = 1'b1;
		void'($urandom(32'h065e));
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		rc(`IDX_DEVICE_STATE, `STATE_RESET, "status");
		rc(`IDX_FAULT_FLAGS, 32'h0, "flags");
		host.xfer(1'b1, 6'h2c, 32'h0, q);
		chk("unmapped", `SLV_DEAD, q);
		for (i = 0; i < 4; i = i + 1) begin
			{lo, mid, hi, dh} = $urandom;
			dh[`DH_LBA] = i[0];
			w(`IDX_ADDR_LOW, {24'h0, lo});
			w(`IDX_ADDR_MID, {24'h0, mid});
			w(`IDX_ADDR_HIGH, {24'h0, hi});
			w(`IDX_DRIVE_HEAD, {24'h0, dh});
			rc(`IDX_START_ADDR, f_start(lo, mid, hi, dh), "start");
		end
		w(`IDX_COUNT_TAG, 32'h0);
		host.issue(`OP_WRITE_MULTI);
		for (i = 0; i < 8 && !pio_write_active; i = i + 1)
			@(posedge ref_clk);
		chk("pio", 32'h1, pio_write_active);
		host.xfer(1'b1, {2'b00, `IDX_CMD_INFO}, 32'h0, q);
		chk("sectors", `SECT_256, (q >> 7) & 32'h1ff);
		lo = ($urandom % 255) + 1;
		w(`IDX_COUNT_TAG, {24'h0, lo});
		host.issue(`OP_WRITE_MULTI);
		host.xfer(1'b1, {2'b00, `IDX_CMD_INFO}, 32'h0, q);
		chk("sectors", {24'h0, lo}, (q >> 7) & 32'h1ff);
		rst_dut;
		for (i = 0; i < 4; i = i + 1) begin
			qcmd(32'h2 | i[0] | (i[1] << `EC_OTHER_READY));
			ev(`EV_DATA_START);
			ev(`EV_DATA_DONE);
			rc(`IDX_COUNT_TAG, f_count(tag, i[0], 1'b0), "count");
			rc(`IDX_DEVICE_STATE, f_stat(dh[4], i[1], 1'b0, 1'b0), "status");
			rc(`IDX_FAULT_FLAGS, 32'h0, "flags");
			rst_dut;
		end
		qcmd(32'h1);
		rc(`IDX_FAULT_FLAGS, 32'h1 << `FF_ABORT_FLAG, "abort");
		rc(`IDX_DEVICE_STATE, f_stat(dh[4], 1'b0, 1'b1, 1'b0), "status");
		rst_dut;
		qcmd(32'h183);
		ev(`EV_DATA_START);
		ev(`EV_CRC_ERR);
		rc(`IDX_FAULT_FLAGS, 32'h84, "crc");
		rc(`IDX_DEVICE_STATE, f_stat(dh[4], 1'b0, 1'b1, 1'b1), "status");
		rc(`IDX_COUNT_TAG, f_count(tag, 1'b1, 1'b0), "count");
		rst_dut;
		qcmd(32'h3);
		{lo, mid} = $urandom;
		ev(`EV_DATA_START);
		w(`IDX_EVENT_CTRL, {mid, lo, 16'h0} | (32'h1 << `EV_MEDIA_ERR));
		rc(`IDX_ADDR_LOW, {24'h0, lo}, "fail_low");
		rc(`IDX_ADDR_MID, {24'h0, mid}, "fail_mid");
		chk("active", 32'h0, dma_write_active);
		rst_dut;
		// Removable medium with pending change, change request and missing address
		qcmd(32'h1f);
		ev(`EV_MEDIA_CHG);
		ev(`EV_CHG_REQ);
		ev(`EV_DATA_START);
		ev(`EV_ADDR_NF);
		rc(`IDX_FAULT_FLAGS, f_flags(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1), "media");
		rc(`IDX_DEVICE_STATE, f_stat(dh[4], 1'b0, 1'b1, 1'b0), "status");
		host.xfer(1'b1, {2'b00, `IDX_CMD_INFO}, 32'h0, q);
		chk("chg_state", 32'h2, (q >> 16) & 32'h3);
		ev(`EV_MEDIA_CMD);
		host.xfer(1'b1, {2'b00, `IDX_CMD_INFO}, 32'h0, q);
		chk("chg_state", 32'h0, (q >> 16) & 32'h3);
		rst_dut;
		qcmd(32'h3);
		ev(`EV_RELEASE);
		@(posedge ref_clk);
		chk("released", 32'h1, bus_released);
		rc(`IDX_COUNT_TAG, f_count(tag, 1'b1, 1'b1), "count");
		ev(`EV_READY_SVC);
		rc(`IDX_DEVICE_STATE, f_stat(dh[4], 1'b1, 1'b0, 1'b0), "status");
		host.service;
		ev(`EV_DATA_START);
		ev(`EV_RELEASE);
		@(posedge ref_clk);
		chk("released", 32'h0, bus_released);
		// Completion write issued while the clock enable is low must wait
		clk_en <= 1'b0;
		fork
			ev(`EV_DATA_DONE);
			begin
				repeat (3) @(posedge ref_clk);
				chk("frozen", 32'h1, dma_write_active);
				clk_en <= 1'b1;
			end
		join
		rc(`IDX_COUNT_TAG, f_count(tag, 1'b1, 1'b0), "count");
		wrap_up;
	end
endmodule
